// ### rtl/sra_device.sv
// device end: serial frame decoder and trim register file
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module sra_device
	import sra_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	input wire logic clock,
	input wire logic rstn,
	sra_if.device link,
	input wire logic cal_offset_valid,
	input wire logic [SLOTS*16-1:0] cal_offset_values,
	output logic offset_cal_enable,
	output logic background_cal_enable,
	output logic [15:0] full_scale_setting,
	output logic [7:0] reference_trim,
	output logic [INPUTS*8-1:0] termination_trim,
	output logic [SLOTS*16-1:0] core_gain_trim,
	output logic [SLOTS*16-1:0] core_offset_trim
);
	typedef enum logic {HDR, DAT} phase_e;

	logic [7:0] regs_reg [REG_N];
	logic [2:0] cs_sync_reg;
	logic [2:0] sclk_sync_reg;
	logic [2:0] sdi_sync_reg;
	logic cs_active;
	logic rise;
	logic bit_in;
	phase_e phase_reg;
	logic [3:0] hdr_cnt_reg;
	logic [14:0] hdr_sr_reg;
	logic [2:0] dat_cnt_reg;
	logic [6:0] din_sr_reg;
	logic rd_reg;
	logic [14:0] addr_reg;
	logic [14:0] addr_next;
	logic [14:0] hdr_addr;
	logic [7:0] dout_reg;
	logic oe_reg;
	logic wr_fire;
	logic [7:0] wr_byte;
	logic cal_fire;

	// byte index of an address, or REG_N when unmapped
	function automatic int idx_of(input logic [14:0] a);
		int r;
		r = REG_N;
		if (a == ADDR_CFG)
			r = IDX_CFG;
		else if (a == ADDR_CAL)
			r = IDX_CAL;
		else if (a >= ADDR_FS && a < ADDR_FS + 15'd2)
			r = IDX_FS + int'(a - ADDR_FS);
		else if (a == ADDR_REF)
			r = IDX_REF;
		else if (a >= ADDR_TERM && a < ADDR_TERM + 15'(INPUTS))
			r = IDX_TERM + int'(a - ADDR_TERM);
		else if (a >= ADDR_OFS && a < ADDR_OFS + 15'(2 * SLOTS))
			r = IDX_OFS + int'(a - ADDR_OFS);
		else if (a >= ADDR_GAIN && a < ADDR_GAIN + 15'(2 * SLOTS))
			r = IDX_GAIN + int'(a - ADDR_GAIN);
		return r;
	endfunction

	// reset image of the byte array
	function automatic logic [7:0] reset_of(input int i);
		logic [7:0] v;
		v = TRIM_RESET;
		if (i == IDX_CFG)
			v = CFG_RESET;
		else if (i == IDX_CAL)
			v = CAL_RESET;
		else if (i == IDX_FS)
			v = FS_RESET[7:0];
		else if (i == IDX_FS + 1)
			v = FS_RESET[15:8];
		return v;
	endfunction

	// read value of an address; unmapped reads zero
	function automatic logic [7:0] read_of(input logic [14:0] a);
		int i;
		logic [7:0] v;
		i = idx_of(a);
		v = 8'h00;
		for (int k = 0; k < REG_N; k++) begin
			if (k == i)
				v = regs_reg[k];
		end
		return v;
	endfunction

	// input pins cross into the clock domain through three flops
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cs_sync_reg <= 3'h7;
			sclk_sync_reg <= 3'h0;
			sdi_sync_reg <= 3'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], link.chip_select_n};
			sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
			sdi_sync_reg <= {sdi_sync_reg[1:0], link.sdi};
		end
	end

	// edges only count inside a frame; no timer anywhere
	assign cs_active = !cs_sync_reg[1] && !cs_sync_reg[2];
	assign rise = cs_active && sclk_sync_reg[1] && !sclk_sync_reg[2];
	assign bit_in = sdi_sync_reg[2];
	assign hdr_addr = {hdr_sr_reg[13:0], bit_in};

	// next streaming address: hold, count up or count down
	always_comb begin
		if (regs_reg[IDX_CFG][CFG_HOLD_BIT])
			addr_next = addr_reg;
		else if (regs_reg[IDX_CFG][CFG_UP_BIT])
			addr_next = addr_reg + 15'd1;
		else
			addr_next = addr_reg - 15'd1;
	end

	// frame sequencer: 16 header bits then bytes of 8
	always_ff @(posedge clock) begin
		if (!rstn) begin
			phase_reg <= HDR;
			hdr_cnt_reg <= 4'h0;
			hdr_sr_reg <= 15'h0000;
			dat_cnt_reg <= 3'h0;
			din_sr_reg <= 7'h00;
			rd_reg <= 1'b0;
			addr_reg <= 15'h0000;
		end else if (!cs_active) begin
			phase_reg <= HDR;
			hdr_cnt_reg <= 4'h0;
			dat_cnt_reg <= 3'h0;
		end else if (rise) begin
			unique case (phase_reg)
				HDR: begin
					hdr_sr_reg <= {hdr_sr_reg[13:0], bit_in};
					hdr_cnt_reg <= hdr_cnt_reg + 4'd1;
					if (hdr_cnt_reg == 4'(HDR_BITS - 1)) begin
						rd_reg <= hdr_sr_reg[14];
						addr_reg <= hdr_addr;
						phase_reg <= DAT;
						dat_cnt_reg <= 3'h0;
					end
				end
				DAT: begin
					din_sr_reg <= {din_sr_reg[5:0], bit_in};
					dat_cnt_reg <= dat_cnt_reg + 3'd1;
					if (dat_cnt_reg == 3'(DATA_W - 1))
						addr_reg <= addr_next;
				end
			endcase
		end
	end

	// byte complete on a write frame
	assign wr_fire = rise && phase_reg == DAT && !rd_reg
		&& dat_cnt_reg == 3'(DATA_W - 1);
	assign wr_byte = {din_sr_reg, bit_in};
	assign cal_fire = cal_offset_valid && regs_reg[IDX_CAL][OFFSET_CAL_ENABLE_BIT]
		&& regs_reg[IDX_CAL][BACKGROUND_CAL_ENABLE_BIT];

	// read data out: load on address or byte end, shift on each other data-phase rise of a read
	always_ff @(posedge clock) begin
		if (!rstn) begin
			dout_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else if (!cs_active) begin
			oe_reg <= 1'b0;
		end else if (rise) begin
			if (phase_reg == HDR && hdr_cnt_reg == 4'(HDR_BITS - 1)) begin
				oe_reg <= hdr_sr_reg[14];
				dout_reg <= read_of(hdr_addr);
			end else if (phase_reg == DAT && rd_reg) begin
				if (dat_cnt_reg == 3'(DATA_W - 1))
					dout_reg <= read_of(addr_next);
				else
					dout_reg <= {dout_reg[6:0], 1'b0};
			end
		end
	end

	assign link.sdo = dout_reg[7];
	assign link.sdo_oe = oe_reg;

	// byte array: serial writes, calibration fills offset trims only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < REG_N; i++)
				regs_reg[i] <= reset_of(i);
		end else begin
			if (wr_fire && idx_of(addr_reg) < REG_N) begin
				for (int i = 0; i < REG_N; i++) begin
					if (i == idx_of(addr_reg))
						regs_reg[i] <= wr_byte;
				end
			end
			if (cal_fire) begin
				for (int s = 0; s < 2 * SLOTS; s++)
					regs_reg[IDX_OFS + s] <= cal_offset_values[s*8 +: 8];
			end
		end
	end

	// control and single full-scale outputs
	assign offset_cal_enable = regs_reg[IDX_CAL][OFFSET_CAL_ENABLE_BIT];
	assign background_cal_enable = regs_reg[IDX_CAL][BACKGROUND_CAL_ENABLE_BIT];
	assign full_scale_setting = {regs_reg[IDX_FS + 1], regs_reg[IDX_FS]};
	assign reference_trim = regs_reg[IDX_REF];

	// termination trims reach only inputs that exist
	for (genvar n = 0; n < INPUTS; n++) begin : g_term
		assign termination_trim[n*8 +: 8] = (n < CHANNELS)
			? regs_reg[IDX_TERM + n] : 8'h00;
	end

	// per-core trims, low byte at the lower address; unused inputs gated
	for (genvar s = 0; s < SLOTS; s++) begin : g_slot
		localparam int INP = (s == 0 || s == 2) ? 0
			: (s == 1 || s == 3) ? 1 : (s == 4 || s == 6) ? 2 : 3;
		localparam bit USED = INP < CHANNELS;
		assign core_gain_trim[s*16 +: 16] = USED
			? {regs_reg[IDX_GAIN + 2*s + 1], regs_reg[IDX_GAIN + 2*s]}
			: 16'h0000;
		assign core_offset_trim[s*16 +: 16] = USED
			? {regs_reg[IDX_OFS + 2*s + 1], regs_reg[IDX_OFS + 2*s]}
			: 16'h0000;
	end
endmodule

// ### rtl/sra_pkg.sv
// shared constants for the serial register access port
package sra_pkg;
	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int HDR_BITS = 1 + ADDR_W;
	// trim slots: cores 0, 1, 2 (a, b), 3 (c, d), 4, 5
	localparam int SLOTS = 8;
	localparam int INPUTS = 4;
	localparam int REG_N = 41;
	// register offsets on the serial bus
	localparam logic [14:0] ADDR_CFG = 15'h0010;
	localparam logic [14:0] ADDR_CAL = 15'h0062;
	localparam logic [14:0] ADDR_FS = 15'h0030;
	localparam logic [14:0] ADDR_REF = 15'h007c;
	localparam logic [14:0] ADDR_TERM = 15'h007e;
	localparam logic [14:0] ADDR_OFS = 15'h0330;
	localparam logic [14:0] ADDR_GAIN = 15'h0340;
	// byte array indices
	localparam int IDX_CFG = 0;
	localparam int IDX_CAL = 1;
	localparam int IDX_FS = 2;
	localparam int IDX_REF = 4;
	localparam int IDX_TERM = 5;
	localparam int IDX_OFS = 9;
	localparam int IDX_GAIN = 25;
	// field positions
	localparam int CFG_HOLD_BIT = 0;
	localparam int CFG_UP_BIT = 1;
	localparam int OFFSET_CAL_ENABLE_BIT = 0;
	localparam int BACKGROUND_CAL_ENABLE_BIT = 1;
	// reset values
	localparam logic [7:0] CFG_RESET = 8'h02;
	localparam logic [7:0] CAL_RESET = 8'h00;
	localparam logic [15:0] FS_RESET = 16'ha000;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	// host serial clock half period at 100 MHz (160 ns period)
	localparam int SCLK_PERIOD_NS = 160;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ### rtl/sra_if.sv
// serial register access link between host and device
`timescale 1ns/1ps
interface sra_if;
	logic chip_select_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;

	modport device (
		input chip_select_n,
		input sclk,
		input sdi,
		output sdo,
		output sdo_oe
	);
	modport host (
		output chip_select_n,
		output sclk,
		output sdi,
		input sdo,
		input sdo_oe
	);
endinterface

// ### rtl/sra_host.sv
// host end: serial bus master that runs single and streaming frames
`timescale 1ns/1ps
module sra_host
	import sra_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	sra_if.host link,
	input wire logic cmd_start,
	input wire logic cmd_read,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	typedef enum logic [1:0] {IDLE, LOW, HIGH, GAP} state_e;

	state_e state_reg;
	logic [7:0] tick_reg;
	logic [23:0] sr_reg;
	logic [4:0] bit_reg;
	logic [7:0] left_reg;
	logic rd_reg;
	logic [7:0] rx_reg;
	logic [1:0] sdo_sync_reg;
	logic half_done;

	assign half_done = tick_reg == 8'(SCLK_HALF - 1);
	assign busy = state_reg != IDLE;
	assign wr_take = (state_reg == IDLE && cmd_start)
		|| (state_reg == HIGH && half_done && bit_reg == 5'd23
		&& left_reg != 8'd1 && !rd_reg);

	// data-out pin synchronised before use
	always_ff @(posedge clock) begin
		if (!rstn)
			sdo_sync_reg <= 2'h0;
		else
			sdo_sync_reg <= {sdo_sync_reg[0], link.sdo};
	end

	// divider sequencer: sclk low half, high half; select held low
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_reg <= IDLE;
			tick_reg <= 8'h00;
			sr_reg <= 24'h000000;
			bit_reg <= 5'h00;
			left_reg <= 8'h00;
			rd_reg <= 1'b0;
			rx_reg <= 8'h00;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			tick_reg <= half_done ? 8'h00 : tick_reg + 8'd1;
			unique case (state_reg)
				IDLE: begin
					tick_reg <= 8'h00;
					if (cmd_start) begin
						sr_reg <= {cmd_read, cmd_addr,
							cmd_read ? 8'h00 : wr_data};
						rd_reg <= cmd_read;
						left_reg <= (cmd_len == 8'h00) ? 8'd1 : cmd_len;
						bit_reg <= 5'h00;
						state_reg <= LOW;
					end
				end
				LOW: if (half_done) begin
					state_reg <= HIGH;
					if (bit_reg >= 5'd16)
						rx_reg <= {rx_reg[6:0], sdo_sync_reg[1]};
				end
				HIGH: if (half_done) begin
					sr_reg <= {sr_reg[22:0], 1'b0};
					state_reg <= LOW;
					if (bit_reg == 5'd23) begin
						if (rd_reg) begin
							rd_data <= rx_reg;
							rd_valid <= 1'b1;
						end
						left_reg <= left_reg - 8'd1;
						bit_reg <= 5'd16;
						sr_reg <= {rd_reg ? 8'h00 : wr_data, 16'h0000};
						if (left_reg == 8'd1)
							state_reg <= GAP;
					end else begin
						bit_reg <= bit_reg + 5'd1;
					end
				end
				GAP: if (half_done)
					state_reg <= IDLE;
			endcase
		end
	end

	// pins: msb of the shift register leads, clock high in HIGH only
	assign link.chip_select_n = !(state_reg == LOW || state_reg == HIGH);
	assign link.sclk = state_reg == HIGH;
	assign link.sdi = sr_reg[23]; // data bytes also leave from the top
endmodule

// ### bench/sra_properties.sv
// protocol checks on the serial access link
`timescale 1ns/1ps
module sra_properties (
	input wire logic clock,
	input wire logic rstn,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic sclk_reg;
	logic rd_reg;
	logic [7:0] rises_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// count serial clock rises per frame, keep the flag bit
	always_ff @(posedge clock) begin
		sclk_reg <= sclk;
		if (!rstn) begin
			rd_reg <= 1'b0;
		end else if (!chip_select_n && sclk && !sclk_reg) begin
			if (rises_reg == 8'h00) begin
				rd_reg <= sdi;
			end
		end
		if (!rstn || chip_select_n) begin
			rises_reg <= 8'h00;
		end else if (sclk && !sclk_reg) begin
			rises_reg <= rises_reg + 8'h01;
		end
	end
	a_sclk_idle_low: assert property (chip_select_n |-> !sclk)
		else $error("serial clock high outside frame");
	a_no_oe_idle: assert property (chip_select_n [*5] |-> !sdo_oe)
		else $error("data out driven while deselected");
	a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("data in moved while serial clock high");
	a_frame_bits: assert property ($rose(chip_select_n) |->
		rises_reg >= 8'h18 && rises_reg[2:0] == 3'h0)
		else $error("frame not 24 plus whole bytes");
	a_oe_after_hdr: assert property ($rose(sdo_oe) |->
		rises_reg == 8'h10 && !chip_select_n)
		else $error("data out enabled off header end");
	a_oe_read_only: assert property (sdo_oe |-> rd_reg)
		else $error("data out driven in write frame");
	a_oe_holds: assert property ($rose(sdo_oe) |-> sdo_oe [*8])
		else $error("data out dropped in data phase");
	a_oe_release: assert property ($rose(chip_select_n) |->
		##[1:5] !sdo_oe)
		else $error("data out not released after frame");
	a_sdo_lag: assert property ($rose(sclk) && sdo_oe |=>
		$stable(sdo) [*2])
		else $error("data out changed too soon after rise");
	cover property ($rose(sdo_oe));
	cover property ($rose(chip_select_n) && rises_reg == 8'h20);
	cover property ($rose(chip_select_n) && !rd_reg);
endmodule

// ### bench/testbench.sv
// self-checking bench for the host and device pair
`timescale 1ns/1ps
module testbench;
	import sra_pkg::*;
	logic clock;
	logic rstn = 1'b0;
	logic cmd_start = 1'b0;
	logic cmd_read = 1'b0;
	logic [14:0] cmd_addr = 15'h0000;
	logic [7:0] cmd_len = 8'h01;
	logic [7:0] wr_data = 8'h00;
	logic cal_offset_valid = 1'b0;
	logic [127:0] cal_offset_values = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
	logic wr_take, rd_valid, busy, offset_cal_enable, background_cal_enable;
	logic [7:0] rd_data, reference_trim;
	logic [31:0] termination_trim;
	logic [15:0] full_scale_setting;
	logic [127:0] core_gain_trim, core_offset_trim;
	logic [7:0] wq [4];
	logic [7:0] rq [4];
	int bad_count = 0;
	int samples_checked = 0;
	sra_if link ();
	sra_host sra_host_i (.clock, .rstn, .link(link), .cmd_start, .cmd_read,
		.cmd_addr, .cmd_len, .wr_data, .wr_take, .rd_data, .rd_valid, .busy);
	// two inputs only, so slots of inputs c and d are unused
	sra_device #(.CHANNELS(2)) sra_device_i (.clock, .rstn, .link(link),
		.cal_offset_valid, .cal_offset_values, .offset_cal_enable,
		.background_cal_enable, .full_scale_setting, .reference_trim,
		.termination_trim, .core_gain_trim, .core_offset_trim);
	sra_properties sra_properties_i (.clock, .rstn,
		.chip_select_n(link.chip_select_n), .sclk(link.sclk),
		.sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
	// free running system clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task results;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task check(input string name, input logic [127:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one command; bytes fed on wr_take, read bytes caught on rd_valid
	task run(input logic rd, input logic [14:0] a, input int n);
		int i, j, k;
		i = 0;
		j = 0;
		for (k = 0; k < 4; k++)
			rq[k] = 8'hxx;
		@(posedge clock);
		cmd_start <= 1'b1;
		cmd_read <= rd;
		cmd_addr <= a;
		cmd_len <= n[7:0];
		wr_data <= wq[0];
		for (k = 0; k < 2000; k++) begin
			@(negedge clock);
			if (wr_take === 1'b1) i++;
			if (rd_valid === 1'b1) begin
				rq[j] = rd_data;
				j++;
			end
			if (k > 0 && busy === 1'b0) break;
			@(posedge clock);
			cmd_start <= 1'b0;
			wr_data <= wq[i % 4];
		end
		check("busy end", busy, 1'b0);
		if (rd)
			check("read count", j, n);
		else
			check("write takes", i, n);
	endtask
	task wr1(input logic [14:0] a, input logic [7:0] d);
		wq[0] = d;
		run(1'b0, a, 1);
	endtask
	task t_reset;
		check("fs", full_scale_setting, FS_RESET);
		check("ref", reference_trim, TRIM_RESET);
		run(1'b1, ADDR_CFG, 1);
		check("cfg", rq[0], CFG_RESET);
	endtask
	task t_single;
		wr1(ADDR_REF, 8'h5a);
		check("ref", reference_trim, 8'h5a);
		run(1'b1, ADDR_REF, 1);
		check("ref rd", rq[0], 8'h5a);
		run(1'b1, 15'h7000, 1);
		check("unmapped", rq[0], 8'h00);
	endtask
	task t_up;
		wq[0] = 8'h34;
		wq[1] = 8'h12;
		run(1'b0, ADDR_FS, 2);
		check("fs up", full_scale_setting, 16'h1234);
		run(1'b1, ADDR_FS, 2);
		check("fs up rd", {rq[1], rq[0]}, 16'h1234);
	endtask
	task t_down;
		wr1(ADDR_CFG, 8'h00);
		wq[0] = 8'h56;
		wq[1] = 8'h78;
		run(1'b0, ADDR_FS + 15'h0001, 2);
		check("fs down", full_scale_setting, 16'h5678);
		run(1'b1, ADDR_FS + 15'h0001, 2);
		check("fs down rd", {rq[0], rq[1]}, 16'h5678);
	endtask
	task t_hold;
		wr1(ADDR_CFG, 8'h01);
		wq[0] = 8'h11;
		wq[1] = 8'h22;
		run(1'b0, ADDR_REF, 2);
		check("ref hold", reference_trim, 8'h22);
		wr1(ADDR_CFG, CFG_RESET);
	endtask
	// calibration result pulse; the link stays idle meanwhile
	task pulse_cal;
		@(posedge clock);
		cal_offset_valid <= 1'b1;
		@(posedge clock);
		cal_offset_valid <= 1'b0;
		repeat (4) @(posedge clock);
		@(negedge clock);
	endtask
	task t_cal;
		wr1(ADDR_GAIN, 8'h77);
		wr1(ADDR_GAIN + 15'h0008, 8'h99);
		wr1(ADDR_CAL, 8'h01);
		pulse_cal;
		check("ofs no bg", core_offset_trim, 128'h0);
		wr1(ADDR_CAL, 8'h03);
		check("offset_cal_enable", offset_cal_enable, 1'b1);
		check("background_cal_enable", background_cal_enable, 1'b1);
		pulse_cal;
		check("ofs", core_offset_trim, {64'h0, cal_offset_values[63:0]});
		check("gain", core_gain_trim[15:0], 16'h0077);
		check("gain unused", core_gain_trim[79:64], 16'h0000);
		run(1'b1, ADDR_GAIN + 15'h0008, 1);
		check("gain unused rd", rq[0], 8'h99);
	endtask
	task t_term;
		wr1(ADDR_TERM, 8'h3c);
		wr1(ADDR_TERM + 15'h0002, 8'h5d);
		check("term", termination_trim, 32'h0000003c);
		run(1'b1, ADDR_TERM + 15'h0002, 1);
		check("term rd", rq[0], 8'h5d);
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset;
		t_single;
		t_up;
		t_down;
		t_hold;
		t_term;
		t_cal;
		results;
	end
	// watchdog against a hung command
	initial begin
		#400000;
		bad_count++;
		results;
	end
endmodule
